/* File: rtl/tbwd_cfg.svh */
// Register offsets, field positions, reset values and keys of the time base.
`ifndef TBWD_CFG_SVH
`define TBWD_CFG_SVH

`define TBWD_ADDR_W        12
`define TBWD_DATA_W        16
`define TBWD_CNT_W         26

`define TBWD_OFS_WD_CTRL   12'h480
`define TBWD_OFS_TIMER     12'h482
`define TBWD_OFS_CNT_KEY   12'h484
`define TBWD_OFS_WD_KEY    12'h485
`define TBWD_OFS_EXT_DIV   12'h487
`define TBWD_OFS_OSC_STOP  12'h48a

`define TBWD_KEY_FIRST     8'ha5
`define TBWD_KEY_SECOND    8'h5a

`define TBWD_WD_IVL_LSB    8
`define TBWD_OSC_STOP_BIT  8
`define TBWD_DIV_LSB       4
`define TBWD_IT_SEL_LSB    11
`define TBWD_IT_EN_BIT     14
`define TBWD_IT_FLAG_BIT   15
`define TBWD_WD_ACT_BIT    0
`define TBWD_WD_FLAG_BIT   1

`define TBWD_DIV_RST       4'h0
`define TBWD_DIV_MAX_M1    4'hf
`define TBWD_DIV_LIN_TOP   4'h7
`define TBWD_RSV_READ      16'h0000

`endif

/* File: rtl/tbwd_pkg.sv */
// Types shared by the time-base, watchdog and clock control block.
`include "tbwd_cfg.svh"

package tbwd_pkg;

  // Device state reported by the state controller, one level per state.
  typedef struct packed {
    logic op_reset;
    logic settings_reset;
    logic stab_wait_reset;
    logic stab_wait_run;
    logic sleep;
    logic stop;
    logic debug_break;
    logic emu_service;
    logic step_trap;
    logic cache_ram_access;
    logic bus_hold_accepted;
    logic sub_clock_selected;
  } tbwd_dev_state_t;

  // Register port request.
  typedef struct packed {
    logic [`TBWD_ADDR_W-1:0] addr;
    logic [`TBWD_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } tbwd_req_t;

  // Complete state of the block.
  typedef struct packed {
    logic [`TBWD_CNT_W-1:0]  tb_cnt;
    logic                    cnt_key_armed;
    logic                    wd_key_armed;
    logic                    wd_active;
    logic [1:0]              wd_interval;
    logic                    wd_flag;
    logic                    wd_tap_prev;
    logic                    wd_reset_req;
    logic [2:0]              it_sel;
    logic                    it_en;
    logic                    it_flag;
    logic                    it_tap_prev;
    logic                    it_irq;
    logic [3:0]              div_sel;
    logic [3:0]              div_cnt;
    logic                    ext_clk_en;
    logic                    main_osc_stop;
    logic [`TBWD_DATA_W-1:0] rdata;
  } tbwd_state_t;

endpackage : tbwd_pkg

/* File: rtl/tbwd_top.sv */
// Time-base counter, watchdog, interval timer and clock control registers.
//
// Operation
// - External bus clock divided 1..8 or 16.
// - Divider field resets to zero, read/write.
// - Stop bit stops main oscillator under sub clock.
// - Writing one ignored while main clock selected.
// - Stop bit resets to zero, read/write.
// - Free-running 26-bit time-base counter.
// - Watchdog starts on first control register write.
// - Watchdog interval latched on first write only.
// - Flag on falling edge; second edge resets.
// - Watchdog stops in reset states until rearmed.
// - Flag cleared while program is suspended.
// - Counter clear also clears watchdog flag.
// - Interval code selects counter tap, falling edge.
// - Flag always set; interrupt only when enabled.
// - Counter runs regardless of interval settings.
// - A5 then 5A key clears the counter.
// - Stop or settings reset clears counter.
// - Watchdog codes select 2^20..2^26 intervals.
// - No automatic clearing during bus hold.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "tbwd_cfg.svh"

module tbwd_top #(
  parameter int WD_BASE_BIT = 19,
  parameter int IT_BASE_BIT = 11,
  parameter int IT_STEP     = 2
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     clk_en,
  input  wire tbwd_pkg::tbwd_req_t      reg_req,
  output logic [`TBWD_DATA_W-1:0]       reg_rdata,
  input  wire tbwd_pkg::tbwd_dev_state_t dev_state,
  output logic                          wd_settings_reset_req,
  output logic                          interval_irq,
  output logic                          ext_bus_clock_en,
  output logic                          main_osc_stop,
  output logic [`TBWD_CNT_W-1:0]        tb_count
);

  // Taps must land inside the counter, or the edges would never come.
  if (WD_BASE_BIT < 0 || WD_BASE_BIT + 6 >= `TBWD_CNT_W)
  begin : g_wd_chk
    $error("Watchdog tap base outside the time-base counter.");
  end
  if (IT_BASE_BIT < 0 || IT_STEP < 0 ||
      IT_BASE_BIT + 7 * IT_STEP >= `TBWD_CNT_W)
  begin : g_it_chk
    $error("Interval tap mapping outside the time-base counter.");
  end

  tbwd_pkg::tbwd_state_t state_reg;
  tbwd_pkg::tbwd_state_t state_next;

  logic [4:0] wd_tap;
  logic [4:0] it_tap;
  logic       wd_tap_now;
  logic       it_tap_now;
  logic       wd_edge;
  logic       it_edge;
  logic       cnt_clear;
  logic       suspended;
  logic       wd_stop;
  logic       wr_wd_ctrl;
  logic       wr_timer;
  logic       wr_cnt_key;
  logic       wr_wd_key;
  logic       wr_div;
  logic       wr_osc;
  logic       wd_key_done;
  logic [7:0] wbyte;
  logic [3:0] div_m1;
  logic [4:0] wd_tap_wr;
  logic [4:0] it_tap_wr;
  logic       wd_arm;
  logic       it_load;

  // Register write decode; one address holds exactly one register.
  assign wbyte      = reg_req.wdata[7:0];
  assign wr_wd_ctrl = reg_req.wr && reg_req.addr == `TBWD_OFS_WD_CTRL;
  assign wr_timer   = reg_req.wr && reg_req.addr == `TBWD_OFS_TIMER;
  assign wr_cnt_key = reg_req.wr && reg_req.addr == `TBWD_OFS_CNT_KEY;
  assign wr_wd_key  = reg_req.wr && reg_req.addr == `TBWD_OFS_WD_KEY;
  assign wr_div     = reg_req.wr && reg_req.addr == `TBWD_OFS_EXT_DIV;
  assign wr_osc     = reg_req.wr && reg_req.addr == `TBWD_OFS_OSC_STOP;

  // Counter taps; the watchdog steps by two bits per code.
  assign wd_tap = 5'(WD_BASE_BIT + 2 * int'(state_reg.wd_interval));
  assign it_tap = 5'(IT_BASE_BIT + IT_STEP * int'(state_reg.it_sel));
  assign wd_tap_now = state_reg.tb_cnt[wd_tap];
  assign it_tap_now = state_reg.tb_cnt[it_tap];
  assign wd_edge = state_reg.wd_tap_prev && !wd_tap_now;
  assign it_edge = state_reg.it_tap_prev && !it_tap_now;

  // Taps that a write is about to select; their present level seeds the
  // edge history, so switching taps cannot fake a falling edge.
  assign wd_tap_wr = 5'(WD_BASE_BIT
                        + 2 * int'(reg_req.wdata[`TBWD_WD_IVL_LSB+:2]));
  assign it_tap_wr = 5'(IT_BASE_BIT
                        + IT_STEP * int'(reg_req.wdata[`TBWD_IT_SEL_LSB+:3]));
  assign wd_arm    = wr_wd_ctrl && !state_reg.wd_active && !wd_stop;
  assign it_load   = wr_timer && !dev_state.op_reset
                     && !dev_state.settings_reset;

  // Counter clear by key, by stop or by the settings reset state.
  assign cnt_clear = (wr_cnt_key && state_reg.cnt_key_armed
                      && wbyte == `TBWD_KEY_SECOND)
                     || dev_state.stop
                     || dev_state.settings_reset;
  assign wd_key_done = wr_wd_key && state_reg.wd_key_armed
                       && wbyte == `TBWD_KEY_SECOND;

  // A held bus is not a suspension, so a long hold can still bite.
  assign suspended = (dev_state.sleep || dev_state.stop
                      || dev_state.stab_wait_run
                      || dev_state.debug_break
                      || dev_state.emu_service
                      || dev_state.step_trap
                      || dev_state.cache_ram_access)
                     && !dev_state.bus_hold_accepted;

  // The reset states park the watchdog until software arms it again.
  assign wd_stop = dev_state.op_reset || dev_state.settings_reset
                   || dev_state.stab_wait_reset;

  // Divider terminal count; undefined codes 8..14 fall back to 16.
  assign div_m1 = (state_reg.div_sel <= `TBWD_DIV_LIN_TOP)
                  ? state_reg.div_sel : `TBWD_DIV_MAX_M1;

  // Next-state logic of the whole block.
  always_comb
  begin
    state_next = state_reg;
    state_next.wd_reset_req = 1'b0;
    state_next.rdata = `TBWD_RSV_READ;

    // The counter never consults the timer settings.
    if (cnt_clear)
    begin
      state_next.tb_cnt = '0;
    end
    else
    begin
      state_next.tb_cnt = state_reg.tb_cnt + 1'b1;
    end

    // Counter key: A5 arms, anything else disarms.
    if (wr_cnt_key)
    begin
      state_next.cnt_key_armed = (wbyte == `TBWD_KEY_FIRST);
    end
    if (wr_wd_key)
    begin
      state_next.wd_key_armed = (wbyte == `TBWD_KEY_FIRST);
    end

    // Forcing the previous taps low after a clear stops the drop to zero
    // from posing as a falling edge.
    if (cnt_clear)
    begin
      state_next.wd_tap_prev = 1'b0;
      state_next.it_tap_prev = 1'b0;
    end
    else
    begin
      state_next.wd_tap_prev = wd_tap_now;
      state_next.it_tap_prev = it_tap_now;
      // A freshly chosen tap starts from its own present level.
      if (wd_arm)
      begin
        state_next.wd_tap_prev = state_reg.tb_cnt[wd_tap_wr];
      end
      if (it_load)
      begin
        state_next.it_tap_prev = state_reg.tb_cnt[it_tap_wr];
      end
    end

    // Watchdog activation, interval latch and flag.
    if (wd_stop)
    begin
      state_next.wd_active = 1'b0;
      state_next.wd_flag = 1'b0;
    end
    else
    begin
      if (wd_arm)
      begin
        state_next.wd_active = 1'b1;
        state_next.wd_interval =
          reg_req.wdata[`TBWD_WD_IVL_LSB+:2];
      end
      if (cnt_clear || suspended)
      begin
        state_next.wd_flag = 1'b0;
      end
      else if (state_reg.wd_active && wd_edge)
      begin
        if (state_reg.wd_flag)
        begin
          state_next.wd_reset_req = 1'b1;
          state_next.wd_flag = 1'b0;
        end
        else
        begin
          state_next.wd_flag = 1'b1;
        end
      end
      else if (wd_key_done)
      begin
        state_next.wd_flag = 1'b0;
      end
    end

    // Interval timer; the operation reset disables it.
    if (dev_state.op_reset || dev_state.settings_reset)
    begin
      state_next.it_sel = '0;
      state_next.it_en = 1'b0;
      state_next.it_flag = 1'b0;
    end
    else
    begin
      if (wr_timer)
      begin
        state_next.it_sel = reg_req.wdata[`TBWD_IT_SEL_LSB+:3];
        state_next.it_en = reg_req.wdata[`TBWD_IT_EN_BIT];
        if (!reg_req.wdata[`TBWD_IT_FLAG_BIT])
        begin
          state_next.it_flag = 1'b0;
        end
      end
      if (it_edge)
      begin
        state_next.it_flag = 1'b1;
      end
    end
    state_next.it_irq = state_next.it_flag && state_next.it_en;

    // Divider and oscillator stop register, cleared by settings reset.
    if (dev_state.settings_reset)
    begin
      state_next.div_sel = `TBWD_DIV_RST;
      state_next.main_osc_stop = 1'b0;
    end
    else
    begin
      if (wr_div)
      begin
        state_next.div_sel = reg_req.wdata[`TBWD_DIV_LSB+:4];
      end
      if (wr_osc)
      begin
        // A one only lands while the sub clock runs the device.
        if (!reg_req.wdata[`TBWD_OSC_STOP_BIT])
        begin
          state_next.main_osc_stop = 1'b0;
        end
        else if (dev_state.sub_clock_selected)
        begin
          state_next.main_osc_stop = 1'b1;
        end
      end
    end

    // External bus clock enable, one pulse per division period.
    if (state_reg.div_cnt >= div_m1)
    begin
      state_next.div_cnt = 4'h0;
      state_next.ext_clk_en = 1'b1;
    end
    else
    begin
      state_next.div_cnt = state_reg.div_cnt + 4'h1;
      state_next.ext_clk_en = 1'b0;
    end

    // Read data for the next cycle; reserved bits read as zero.
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `TBWD_OFS_WD_CTRL:
        begin
          state_next.rdata[`TBWD_WD_IVL_LSB+:2] = state_reg.wd_interval;
          state_next.rdata[`TBWD_WD_ACT_BIT] = state_reg.wd_active;
          state_next.rdata[`TBWD_WD_FLAG_BIT] = state_reg.wd_flag;
        end
        `TBWD_OFS_TIMER:
        begin
          state_next.rdata[`TBWD_IT_SEL_LSB+:3] = state_reg.it_sel;
          state_next.rdata[`TBWD_IT_EN_BIT] = state_reg.it_en;
          state_next.rdata[`TBWD_IT_FLAG_BIT] = state_reg.it_flag;
        end
        `TBWD_OFS_EXT_DIV:
        begin
          state_next.rdata[`TBWD_DIV_LSB+:4] = state_reg.div_sel;
        end
        `TBWD_OFS_OSC_STOP:
        begin
          state_next.rdata[`TBWD_OSC_STOP_BIT] =
            state_reg.main_osc_stop;
        end
        default:
        begin
          state_next.rdata = `TBWD_RSV_READ;
        end
      endcase
    end
  end

  // State register; a low clock enable freezes everything, the counter
  // included, so watchdog and timer periods stretch by the frozen cycles.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // All outputs come straight from the state register.
  assign reg_rdata             = state_reg.rdata;
  assign wd_settings_reset_req = state_reg.wd_reset_req;
  assign interval_irq          = state_reg.it_irq;
  assign ext_bus_clock_en      = state_reg.ext_clk_en;
  assign main_osc_stop         = state_reg.main_osc_stop;
  assign tb_count              = state_reg.tb_cnt;

endmodule : tbwd_top

/* File: testbench/tbwd_checker_assertions.sv */
// Port checker of the time base and watchdog block, bound to its top.
`timescale 1ns/1ps
`include "tbwd_cfg.svh"

module tbwd_checker #(
  parameter int WD_BASE_BIT = 19
) (
  input wire logic                      ref_clk,
  input wire logic                      reset_n,
  input wire logic                      clk_en,
  input wire tbwd_pkg::tbwd_req_t       reg_req,
  input wire logic [`TBWD_DATA_W-1:0]   reg_rdata,
  input wire tbwd_pkg::tbwd_dev_state_t dev_state,
  input wire logic                      wd_settings_reset_req,
  input wire logic                      interval_irq,
  input wire logic                      main_osc_stop,
  input wire logic [`TBWD_CNT_W-1:0]    tb_count
);
  // A stop control write, decoded once for the oscillator checks.
  wire osc_wr = reg_req.wr && reg_req.addr == `TBWD_OFS_OSC_STOP;
  wire sub    = dev_state.sub_clock_selected;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Read data stand only in the cycle after a read strobe.
  rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 0)
    else $error("read data outside a read answer");
  cnt_step_a: assert property (
    $past(clk_en) |-> tb_count == $past(tb_count) + 1 || tb_count == 0)
    else $error("time base counter skipped");
  freeze_hold_a: assert property (
    !$past(clk_en) |-> $stable(tb_count))
    else $error("time base moved while frozen");
  cnt_clear_a: assert property (
    dev_state.stop || dev_state.settings_reset |=> tb_count == 0)
    else $error("time base not cleared");
  osc_init_a: assert property (
    dev_state.settings_reset |=> !main_osc_stop)
    else $error("stop bit survived settings reset");
  osc_ignore_a: assert property (
    osc_wr && !sub && !main_osc_stop |=> !main_osc_stop)
    else $error("stop bit set under main clock");
  osc_set_a: assert property (
    osc_wr && sub && reg_req.wdata[`TBWD_OSC_STOP_BIT]
    && !dev_state.settings_reset |=> main_osc_stop)
    else $error("stop bit not set under sub clock");
  osc_cause_a: assert property (
    $rose(main_osc_stop) |-> $past(osc_wr && sub))
    else $error("oscillator stopped without a write");
  // The request is a single pulse launched just after a tap edge.
  wd_pulse_a: assert property (
    wd_settings_reset_req |=> !wd_settings_reset_req)
    else $error("watchdog request longer than a pulse");
  wd_tap_a: assert property (
    wd_settings_reset_req |-> tb_count[WD_BASE_BIT:0] inside {[0:2]})
    else $error("watchdog request away from a tap edge");

  cover property (wd_settings_reset_req);
  cover property (interval_irq);
  cover property ($rose(main_osc_stop));
endmodule : tbwd_checker

bind tbwd_top tbwd_checker #(.WD_BASE_BIT(WD_BASE_BIT)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .dev_state(dev_state),
  .wd_settings_reset_req(wd_settings_reset_req),
  .interval_irq(interval_irq), .main_osc_stop(main_osc_stop),
  .tb_count(tb_count)
);

/* File: testbench/tbwd_top_tb_top.sv */
// Self-checking bench of the time base, watchdog and clock control.
`timescale 1ns/1ps
`include "tbwd_cfg.svh"

module tbwd_top_tb_top;
  localparam logic [11:0] A_WD = `TBWD_OFS_WD_CTRL;
  localparam logic [11:0] A_IT = `TBWD_OFS_TIMER;
  localparam logic [11:0] A_CK = `TBWD_OFS_CNT_KEY;
  localparam logic [11:0] A_DV = `TBWD_OFS_EXT_DIV;
  localparam logic [11:0] A_OS = `TBWD_OFS_OSC_STOP;
  localparam int          IB   = 2;
  logic                      ref_clk   = 1'b0;
  logic                      reset_n   = 1'b0;
  logic                      clk_en    = 1'b1;
  logic [25:0]               cnt_hold;
  int                        n_seen    = 0;
  tbwd_pkg::tbwd_req_t       reg_req   = '0;
  tbwd_pkg::tbwd_dev_state_t dev_state = '0;
  logic [15:0]               rdata;
  logic [15:0]               rd_val;
  logic [15:0]               lfsr_q    = 16'h7164;
  logic [2:0]                sel;
  logic [25:0]               cnt;
  logic                      wd_req;
  logic                      irq;
  logic                      ext_en;
  logic                      osc_stop;
  logic [3:0]                codes [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 15, 10};
  int                        n_errors   = 0;
  int                        num_checks = 0;
  int                        n_wd       = 0;
  int                        cycles     = 0;
  int                        k;

  // Small taps keep the watchdog and timer periods short.
  tbwd_top #(.WD_BASE_BIT(3), .IT_BASE_BIT(IB), .IT_STEP(1)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(rdata), .dev_state(dev_state),
    .wd_settings_reset_req(wd_req), .interval_irq(irq),
    .ext_bus_clock_en(ext_en), .main_osc_stop(osc_stop), .tb_count(cnt));

  always #5 ref_clk = ~ref_clk;

  // Counts watchdog requests and cuts a hung run short.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (wd_req === 1'b1)
      n_wd <= n_wd + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      finish_test();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // Codes 8 to 14 fall back to the slowest ratio.
  function automatic int div_n(input logic [3:0] c);
    return (c <= 4'h7) ? c + 1 : 16;
  endfunction : div_n

  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge ref_clk) reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge ref_clk) reg_req.rd <= 1'b0;
    @(negedge ref_clk) rd_val = rdata;
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic cnt_clear();
    wr(A_CK, 16'h00a5);
    wr(A_CK, 16'h005a);
  endtask : cnt_clear

  // Waits for a new watchdog request; the counter itself has one writer.
  task automatic wait_wd(input int lim);
    int n0;
    n0 = n_wd;
    k  = 0;
    while (n_wd == n0 && k < lim)
    begin
      @(posedge ref_clk);
      k++;
    end
    n_seen = n_wd - n0;
  endtask : wait_wd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Main sequence: each block of steps exercises one function.
  initial
  begin
    tick(2);
    reset_n <= 1'b1;
    rd(A_DV);
    check(rd_val, 0);
    rd(A_OS);
    check(rd_val, 0);
    rd(A_WD);
    check(rd_val, 0);
    rd(12'h4ff);
    check(rd_val, 0);
    foreach (codes[i])
    begin
      wr(A_DV, {8'h00, codes[i], 4'hf});
      rd(A_DV);
      check(rd_val, {codes[i], 4'h0});
      repeat (3)
      begin
        k = 1;
        @(negedge ref_clk);
        while (ext_en !== 1'b1 && k < 20)
        begin
          @(negedge ref_clk);
          k++;
        end
      end
      check(k, div_n(codes[i]));
    end
    // A low enable must freeze the counter across six clock edges.
    @(posedge ref_clk) clk_en <= 1'b0;
    @(negedge ref_clk) cnt_hold = cnt;
    tick(6);
    @(negedge ref_clk);
    check(cnt, cnt_hold);
    @(posedge ref_clk) clk_en <= 1'b1;
    wr(A_OS, 16'h0100);
    rd(A_OS);
    check(rd_val, 0);
    @(posedge ref_clk) dev_state.sub_clock_selected <= 1'b1;
    wr(A_OS, 16'hff00);
    rd(A_OS);
    check(rd_val, 16'h0100);
    check(osc_stop, 1'b1);
    @(posedge ref_clk) dev_state.settings_reset <= 1'b1;
    @(posedge ref_clk) dev_state.settings_reset <= 1'b0;
    rd(A_DV);
    check(rd_val, 0);
    rd(A_OS);
    check(rd_val, 0);
    @(posedge ref_clk) dev_state <= '0;
    // A foreign value between the keys must disarm the clear.
    lfsr_q = lfsr(lfsr_q);
    wr(A_CK, 16'h00a5);
    wr(A_CK, {9'h000, lfsr_q[6:1], 1'b1});
    wr(A_CK, 16'h005a);
    @(negedge ref_clk);
    check(cnt < 5, 1'b0);
    cnt_clear();
    @(negedge ref_clk);
    check(cnt, 0);
    repeat (2)
    begin
      lfsr_q = lfsr(lfsr_q);
      sel    = 3'd3 + lfsr_q[2:0] % 3'd5;
      wr(A_IT, {2'b00, sel, 11'h000});
      cnt_clear();
      tick((1 << (IB + sel + 1)) + 4);
      rd(A_IT);
      check(rd_val, {2'b10, sel, 11'h000});
      check(irq, 1'b0);
      wr(A_IT, {2'b11, sel, 11'h000});
      tick(1);
      @(negedge ref_clk);
      check(irq, 1'b1);
      wr(A_IT, {2'b01, sel, 11'h000});
      tick(1);
      @(negedge ref_clk);
      check(irq, 1'b0);
    end
    // Watchdog: interval 1 latched, later interval 3 refused.
    wr(A_WD, 16'h0100);
    wr(A_WD, 16'h0300);
    rd(A_WD);
    check(rd_val, 16'h0101);
    cnt_clear();
    tick(80);
    rd(A_WD);
    check(rd_val, 16'h0103);
    wr(`TBWD_OFS_WD_KEY, 16'h00a5);
    wr(`TBWD_OFS_WD_KEY, 16'h005a);
    rd(A_WD);
    check(rd_val, 16'h0101);
    wait_wd(200);
    check(k > 60 && k < 200, 1'b1);
    for (int i = 2; i < 9; i++)
    begin
      @(posedge ref_clk) dev_state <= 12'h001 << i;
      wait_wd(150);
      check(n_seen, 0);
    end
    @(posedge ref_clk) dev_state <= 12'h082;
    wait_wd(200);
    check(n_seen, 1);
    @(posedge ref_clk) dev_state <= 12'h800;
    @(posedge ref_clk) dev_state <= 12'h000;
    rd(A_WD);
    check(rd_val[0], 1'b0);
    // A fresh count keeps the short tap from falling before the read.
    cnt_clear();
    wr(A_WD, 16'h0000);
    rd(A_WD);
    check(rd_val, 16'h0001);
    finish_test();
  end
endmodule : tbwd_top_tb_top
